// [cfg_regs_cfg.svh]
// Register offsets, field positions, reset values and power state codes
// Functional notes
// - Style bit 0 lets one instruction carry many successive data bytes.
// - Streaming steps the address after each byte, direction from stepUp bit.
// - Style bit 1 allows exactly one data byte per instruction.
// - Power state 00 keeps the device running normally.
// - Power state 11 powers down, same as the power-down pin high.
// - Read-only four-bit part class in low nibble, upper nibble reserved.
// - Read-only part number, low byte at lower address, high byte next.
// - Read-only byte: grade in upper nibble, revision in lower nibble.
// - Scratch byte stores writes and returns them, with no side effect.
// - Interface revision: type in bits 7:6, version in bits 5:0.
// - Read-only maker code over two bytes, low byte first.
// - Loop length sets bytes streamed before address returns to start.
// - Loop length zero disables looping; address wraps at map ends.
// - Looping spans at most 255 bytes.
// - Step bit 0 decrements address by one, 1 increments by one.
`ifndef CFG_REGS_CFG_SVH
`define CFG_REGS_CFG_SVH
`define OFS_STEP_CFG      8'h00
`define OFS_STYLE_CFG     8'h01
`define OFS_POWER_CFG     8'h02
`define OFS_CLASS         8'h03
`define OFS_PARTNUM_LO    8'h04
`define OFS_PARTNUM_HI    8'h05
`define OFS_GRADE_REV     8'h06
`define OFS_TEST_BYTE     8'h0a
`define OFS_IF_REV        8'h0b
`define OFS_MAKER_LO      8'h0c
`define OFS_MAKER_HI      8'h0d
`define OFS_REPEAT_SPAN   8'h0e
`define ADDR_TOP          8'hff
`define POS_STEP_UP       5
`define POS_STYLE         7
`define RST_POWER_RSVD    6'h3c
`define RST_POWER_CFG     8'hf0
`define RST_BYTE          8'h00
`define PWR_NORMAL        2'h0
`define PWR_DOWN          2'h3
`endif

// [cfg_regs_pkg.sv]
// Types shared by the configuration register block
package cfg_regs_pkg;
  typedef enum logic [1:0] {PH_INSTR, PH_DATA, PH_IGNORE} phase_t;
  typedef logic [7:0] byte_t;
endpackage

// [spi_config_identity_regs.sv]
// SPI configuration and identification registers, sampled on the system clock
`timescale 1ns/100ps
`default_nettype none
`include "cfg_regs_cfg.svh"
module spi_config_identity_regs
#(
  parameter logic [3:0]  PART_CLASS   = 4'h1, // Arbitrary value
  parameter logic [15:0] PART_NUMBER  = 16'h1234, // Arbitrary value
  parameter logic [3:0]  GRADE        = 4'h1, // Arbitrary value
  parameter logic [3:0]  REVISION     = 4'h1, // Arbitrary value
  parameter logic [1:0]  IF_TYPE      = 2'h1, // Arbitrary value
  parameter logic [5:0]  IF_VERSION   = 6'h01, // Arbitrary value
  parameter logic [15:0] MAKER_CODE   = 16'hbeef // Arbitrary value
)
(
  // System
  input  wire logic clock,
  input  wire logic resetn,
  // Serial configuration port pins
  input  wire logic csn,
  input  wire logic sclk,
  input  wire logic mosi,
  output var  logic miso,
  output var  logic misoOe,
  // Power control
  input  wire logic powerdown_pin,
  output var  logic powerDown
);
  // Pins from outside the clock domain
  // Select inverted so the reset value matches a deselected pin
  logic csActS;
  logic sclkS;
  logic mosiS;
  sync_two_ff u_sync_cs   (.clock(clock), .resetn(resetn), .din(~csn), .dout(csActS));
  sync_two_ff u_sync_clk  (.clock(clock), .resetn(resetn), .din(sclk), .dout(sclkS));
  sync_two_ff u_sync_data (.clock(clock), .resetn(resetn), .din(mosi), .dout(mosiS));
  logic pdS;
  sync_two_ff u_sync_pd   (.clock(clock), .resetn(resetn), .din(powerdown_pin), .dout(pdS));

  // Register state
  logic        stepUp_r;
  logic        style_r;
  logic [1:0]  powerSel_r;
  logic [7:0]  testByte_r;
  logic [7:0]  repeatSpan_r;

  // Frame state
  cfg_regs_pkg::phase_t phase_r;
  logic        sclkD_r;
  logic [15:0] shift_r;
  logic [4:0]  bitCnt_r;
  logic        isRead_r;
  logic [7:0]  addr_r;
  logic [7:0]  startAddr_r;
  logic [7:0]  loopCnt_r;
  logic [7:0]  outByte_r;

  wire sclkRise = sclkS & ~sclkD_r;
  wire sclkFall = ~sclkS & sclkD_r;
  wire inFrame  = csActS;
  wire [7:0] rxByte = {shift_r[6:0], mosiS};
  wire instrDone = inFrame && sclkRise && phase_r == cfg_regs_pkg::PH_INSTR
                   && bitCnt_r == 5'd15;
  wire dataDone  = inFrame && sclkRise && phase_r == cfg_regs_pkg::PH_DATA
                   && bitCnt_r == 5'd7;
  wire [7:0] instrAddr = rxByte;

  // Read mux; reserved bits read their defaults
  function automatic logic [7:0] readMux(input logic [7:0] a);
    begin
      case (a)
        `OFS_STEP_CFG:    readMux = {2'b00, stepUp_r, 5'b00000};
        `OFS_STYLE_CFG:   readMux = {style_r, 7'h00};
        `OFS_POWER_CFG:   readMux = {`RST_POWER_RSVD, powerSel_r};
        `OFS_CLASS:       readMux = {4'h0, PART_CLASS};
        `OFS_PARTNUM_LO:  readMux = PART_NUMBER[7:0];
        `OFS_PARTNUM_HI:  readMux = PART_NUMBER[15:8];
        `OFS_GRADE_REV:   readMux = {GRADE, REVISION};
        `OFS_TEST_BYTE:   readMux = testByte_r;
        `OFS_IF_REV:      readMux = {IF_TYPE, IF_VERSION};
        `OFS_MAKER_LO:    readMux = MAKER_CODE[7:0];
        `OFS_MAKER_HI:    readMux = MAKER_CODE[15:8];
        `OFS_REPEAT_SPAN: readMux = repeatSpan_r;
        default:          readMux = 8'h00;
      endcase
    end
  endfunction

  // Next address: loop back, else step with wrap at map ends
  logic [7:0] stepAddr;
  logic [7:0] nextAddr;
  logic       loopWrap;
  assign stepAddr = stepUp_r ? 8'(addr_r + 8'h01) : 8'(addr_r - 8'h01);
  assign loopWrap = (repeatSpan_r != 8'h00) && (loopCnt_r == 8'(repeatSpan_r - 8'h01));
  assign nextAddr = loopWrap ? startAddr_r : stepAddr;
  wire [7:0] loopCntNxt = loopWrap ? 8'h00 : 8'(loopCnt_r + 8'h01);

  // Instruction: bit15 read flag, bits 7:0 address, bits 14:8 ignored
  wire instrRead = shift_r[14];

  // Shift and phase control
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sclkD_r <= 1'b0;
      phase_r <= cfg_regs_pkg::PH_INSTR;
      shift_r <= 16'h0000;
      bitCnt_r <= 5'd0;
      isRead_r <= 1'b0;
      addr_r <= 8'h00;
      startAddr_r <= 8'h00;
      loopCnt_r <= 8'h00;
    end
    else
    begin
      sclkD_r <= sclkS;
      if (!inFrame)
      begin
        phase_r  <= cfg_regs_pkg::PH_INSTR;
        bitCnt_r <= 5'd0;
      end
      else if (sclkRise)
      begin
        shift_r <= {shift_r[14:0], mosiS};
        case (phase_r)
          cfg_regs_pkg::PH_INSTR:
          begin
            bitCnt_r <= 5'(bitCnt_r + 5'd1);
            if (instrDone)
            begin
              phase_r     <= cfg_regs_pkg::PH_DATA;
              bitCnt_r    <= 5'd0;
              isRead_r    <= instrRead;
              addr_r      <= instrAddr;
              startAddr_r <= instrAddr;
              loopCnt_r   <= 8'h00;
            end
          end
          cfg_regs_pkg::PH_DATA:
          begin
            bitCnt_r <= 5'(bitCnt_r + 5'd1);
            if (dataDone)
            begin
              bitCnt_r <= 5'd0;
              if (style_r)
                phase_r <= cfg_regs_pkg::PH_IGNORE;
              else
              begin
                addr_r    <= nextAddr;
                loopCnt_r <= loopCntNxt;
              end
            end
          end
          default: phase_r <= cfg_regs_pkg::PH_IGNORE;
        endcase
      end
    end
  end

  wire doWrite = dataDone && !isRead_r;

  // Writable fields; writes to read-only or reserved bits are dropped
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      stepUp_r     <= 1'b0;
      style_r      <= 1'b0;
      powerSel_r   <= `PWR_NORMAL;
      testByte_r   <= `RST_BYTE;
      repeatSpan_r <= `RST_BYTE;
    end
    else if (doWrite)
    begin
      case (addr_r)
        `OFS_STEP_CFG:    stepUp_r     <= rxByte[`POS_STEP_UP];
        `OFS_STYLE_CFG:   style_r      <= rxByte[`POS_STYLE];
        `OFS_POWER_CFG:   powerSel_r   <= rxByte[1:0];
        `OFS_TEST_BYTE:   testByte_r   <= rxByte;
        `OFS_REPEAT_SPAN: repeatSpan_r <= rxByte;
        default:          stepUp_r     <= stepUp_r;
      endcase
    end
  end

  // Read data shifted out MSB first, changed on falling clock
  wire readPhase = inFrame && phase_r == cfg_regs_pkg::PH_DATA && isRead_r;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      outByte_r <= 8'h00;
      miso      <= 1'b0;
      misoOe    <= 1'b0;
    end
    else
    begin
      misoOe <= readPhase;
      if (instrDone)
        outByte_r <= readMux(instrAddr);
      else if (dataDone && !style_r)
        outByte_r <= readMux(nextAddr);
      else if (readPhase && sclkFall)
      begin
        miso      <= outByte_r[7];
        outByte_r <= {outByte_r[6:0], 1'b0};
      end
    end
  end

  // Power-down: software 11 or pin high
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      powerDown <= 1'b0;
    else
      powerDown <= pdS | (powerSel_r == `PWR_DOWN);
  end

  a_power_down: assert property (@(posedge clock) disable iff (!resetn)
    (powerSel_r == `PWR_DOWN) |=> powerDown)
    else $error("power state 11 did not power down");
  a_power_normal: assert property (@(posedge clock) disable iff (!resetn)
    (powerSel_r == `PWR_NORMAL && !pdS) |=> !powerDown)
    else $error("normal power state still powered down");
  a_single_byte: assert property (@(posedge clock) disable iff (!resetn)
    (dataDone && style_r) |=> phase_r == cfg_regs_pkg::PH_IGNORE)
    else $error("single byte mode accepted more data");
  a_stream_step: assert property (@(posedge clock) disable iff (!resetn)
    (dataDone && !style_r && !loopWrap && stepUp_r)
      |=> addr_r == 8'($past(addr_r) + 8'h01))
    else $error("ascending step wrong");
  a_stream_down: assert property (@(posedge clock) disable iff (!resetn)
    (dataDone && !style_r && !loopWrap && !stepUp_r)
      |=> addr_r == 8'($past(addr_r) - 8'h01))
    else $error("descending step wrong");
  a_loop_back: assert property (@(posedge clock) disable iff (!resetn)
    (dataDone && !style_r && loopWrap) |=> addr_r == startAddr_r)
    else $error("loop did not return to start");
  a_loop_off: assert property (@(posedge clock) disable iff (!resetn)
    (dataDone && !style_r && repeatSpan_r == 8'h00)
      |=> addr_r == ($past(stepUp_r) ? 8'($past(addr_r) + 8'h01)
                                     : 8'($past(addr_r) - 8'h01)))
    else $error("zero loop length did not keep stepping");
  a_test_store: assert property (@(posedge clock) disable iff (!resetn)
    (doWrite && addr_r == `OFS_TEST_BYTE) |=> testByte_r == $past(rxByte))
    else $error("scratch byte not stored");
endmodule
`default_nettype wire

// [spi_config_identity_regs_test.sv]
// Self-checking testbench for the configuration and identity registers
`timescale 1ns/100ps
`default_nettype none
module spi_config_identity_regs_test;
  // Arbitrary identity values
  localparam logic [3:0]  CLS = 4'h9;
  localparam logic [15:0] PN  = 16'ha5c3;
  localparam logic [7:0]  GR  = 8'hb5;
  localparam logic [7:0]  IFR = 8'h6a;
  localparam logic [15:0] MK  = 16'hd1e8;
  logic clock;
  logic resetn;
  logic pinPd;
  wire logic csn;
  wire logic sclk;
  wire logic mosi;
  wire logic miso;
  wire logic misoOe;
  wire logic powerDown;
  int err_total = 0;
  int comparisons = 0;
  spi_config_identity_regs #(
    .PART_CLASS (CLS),
    .PART_NUMBER(PN),
    .GRADE      (GR[7:4]),
    .REVISION   (GR[3:0]),
    .IF_TYPE    (IFR[7:6]),
    .IF_VERSION (IFR[5:0]),
    .MAKER_CODE (MK)
  ) uut (
    .clock        (clock),
    .resetn       (resetn),
    .csn          (csn),
    .sclk         (sclk),
    .mosi         (mosi),
    .miso         (miso),
    .misoOe       (misoOe),
    .powerdown_pin(pinPd),
    .powerDown    (powerDown)
  );
  spi_host_model host (
    .clock(clock),
    .miso (miso),
    .csn  (csn),
    .sclk (sclk),
    .mosi (mosi)
  );
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input int n, input logic [31:0] exp);
    logic [31:0] d;
    // 200 clocks into a frame lies inside its first data byte
    fork
      host.frame(1'b1, a, n, 32'h0, d);
      begin
        repeat (200) @(posedge clock);
        check(32'(misoOe), 32'h1);
      end
    join
    check(d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input int n, input logic [31:0] d);
    logic [31:0] x;
    fork
      host.frame(1'b0, a, n, d, x);
      begin
        repeat (200) @(posedge clock);
        check(32'(misoOe), 32'h0);
      end
    join
  endtask
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // About 31 frames of roughly 250 to 500 clocks each
  initial
  begin
    repeat (40000) @(posedge clock);
    err_total++;
    $display("unexpected at %0t: run did not finish", $time);
    test_done();
  end
  initial
  begin
    resetn = 1'b0;
    pinPd  = 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    rd(8'h01, 1, 32'h00);
    rd(8'h02, 1, 32'hf0);
    rd(8'h0a, 1, 32'h00);
    rd(8'h0e, 1, 32'h00);
    $display("reset values test done");
    rd(8'h03, 1, 32'(CLS));
    rd(8'h04, 1, 32'(PN[7:0]));
    rd(8'h05, 1, 32'(PN[15:8]));
    rd(8'h06, 1, 32'(GR));
    rd(8'h0b, 1, 32'(IFR));
    rd(8'h0c, 1, 32'(MK[7:0]));
    rd(8'h0d, 1, 32'(MK[15:8]));
    $display("identity test done");
    wr(8'h0a, 1, 32'h5a);
    rd(8'h0a, 1, 32'h5a);
    wr(8'h02, 1, 32'hff);
    rd(8'h02, 1, 32'hf3);
    check(32'(powerDown), 32'h1);
    wr(8'h02, 1, 32'h00);
    check(32'(powerDown), 32'h0);
    pinPd <= 1'b1;
    repeat (6) @(posedge clock);
    check(32'(powerDown), 32'h1);
    pinPd <= 1'b0;
    repeat (6) @(posedge clock);
    $display("power test done");
    wr(8'h01, 1, 32'hff);
    rd(8'h01, 1, 32'h80);
    wr(8'h02, 2, 32'h0003);
    rd(8'h01, 1, 32'h80);
    rd(8'h02, 1, 32'hf3);
    wr(8'h01, 1, 32'h00);
    $display("single byte test done");
    wr(8'h00, 1, 32'h20);
    wr(8'h00, 3, 32'h030020);
    rd(8'h00, 3, 32'h00f30020);
    wr(8'hff, 2, 32'h0011);
    rd(8'h02, 2, 32'h00f3);
    wr(8'h00, 1, 32'h20);
    wr(8'h0e, 1, 32'h02);
    rd(8'h0e, 1, 32'h02);
    rd(8'h0a, 4, {IFR, 8'h5a, IFR, 8'h5a});
    $display("streaming test done");
    test_done();
  end
endmodule
`default_nettype wire

// [spi_host_model.sv]
// Host controller model for the serial configuration port
`timescale 1ns/100ps
`default_nettype none
module spi_host_model
(
  // System
  input  wire logic clock,
  // Serial pins
  input  wire logic miso,
  output var  logic csn,
  output var  logic sclk,
  output var  logic mosi
);
  initial
  begin
    csn  = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // Five clocks per level, above the synchroniser minimum of four
  task automatic half(output logic q);
    repeat (5) @(posedge clock);
    q = miso;
  endtask
  // Byte k of wd and rdata travels as the k-th data byte, MSB first
  task automatic frame(input logic rd, input logic [7:0] addr, input int n,
                       input logic [31:0] wd, output logic [31:0] rdata);
    logic [15:0] ins;
    logic        q;
    int          p;
    ins   = {rd, 7'h00, addr};
    rdata = 32'h0;
    csn <= 1'b0;
    for (int i = 0; i < 16 + 8 * n; i++)
    begin
      p = 8 * ((i - 16) / 8) + 7 - (i % 8);
      sclk <= 1'b0;
      mosi <= (i < 16) ? ins[15 - i] : wd[p];
      half(q);
      if (i >= 16)
        rdata[p] = q;
      sclk <= 1'b1;
      half(q);
    end
    sclk <= 1'b0;
    half(q);
    csn  <= 1'b1;
    // Released line must not keep showing the last bit
    mosi <= ~mosi;
    repeat (8) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// [sync_two_ff.sv]
// Two flip-flop synchroniser for one pin level
`timescale 1ns/100ps
`default_nettype none
module sync_two_ff
(
  // System
  input  wire logic clock,
  input  wire logic resetn,
  // Level
  input  wire logic din,
  output var  logic dout
);
  logic stage1_r;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1_r <= 1'b0;
      dout     <= 1'b0;
    end
    else
    begin
      stage1_r <= din;
      dout     <= stage1_r;
    end
  end
endmodule
`default_nettype wire
